// file: design/ppmih_sync.sv
// Three-stage synchroniser for pins from outside the core clock domain.
// Assumes rstn synchronous; output moves only when stages two and three agree.
`timescale 1ns/10ps
module ppmih_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Raw and settled levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Stage one feeds only stage two, keeping metastability contained
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < W; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          q_out[k] <= s3_q[k];
        end
      end
    end
  end
endmodule // ppmih_sync

// file: design/ppmih_top.sv
// Two 8-bit mode-0 parallel ports with submode-00 input handshake, APB slave.
// Assumes one core clock; all pins are asynchronous and are synchronised here.
// Contract
// - Alternate registers return live pin levels, reads have no side effect.
// - Port A control: submode 7:6, aux 5:3, aux irq 2, service 1, strobe 0.
// - Port B control uses the same field layout for port B.
// - Both control registers reset to zero, are read/write, reads harmless.
// - Mode 0 ports are independent, each in submode 00, 01 or 1X.
// - Port A and B transfers enabled by their handshake enable bits.
// - Transfer request pin serves one port, inactive when that port is 1X.
// - Data read: dir 0 gives input latch in 00, pin otherwise; dir 1 output latch.
// - Submodes 00 and 1X load output latch single buffered, dir drives pin.
// - Submode 01 writes go double buffered, final latch drives output pins.
// - Each direction bit enables its pin driver in every submode.
// - Submode 00 captures pins on strobe edge into a two-deep buffer.
// - Strobe flag set while unread input data is buffered.
// - Status-input aux sets flag on edge; cleared by reset, write one, disable.
// - General-purpose aux output held negated or asserted, flag stays clear.
// - Interlocked aux asserts while space exists, drops on strobe edge.
// - Interlocked strobes while aux negated are ignored.
// - Pulsed aux is a four-cycle pulse, cut short by a strobe edge.
// - Interlocked and pulsed aux held negated while handshake disabled.
// - Submode 00 output writes affect no handshake pin or flag.
// - A data register read removes received data from the buffer.
// - Aux decode: 0XX input, 100 negated, 101 asserted, 110 locked, 111 pulsed.
// - Service enable gates both strobe service request and transfer request.
// - Disabled handshake controller held empty.
// - Sense bits invert handshake pin polarity, reset low-active.
`timescale 1ns/10ps
`include "ppmih_consts.svh"
module ppmih_top
  import ppmih_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port A pins
  input  wire logic [7:0]  port_a_pins_in,
  output logic      [7:0]  port_a_pins_out,
  output logic      [7:0]  port_a_pins_oe,
  input  wire logic        port_a_strobe_input,
  input  wire logic        port_a_aux_handshake_in,
  output logic             port_a_aux_handshake_out,
  output logic             port_a_aux_handshake_oe,
  output logic             port_a_service_request,
  // Port B pins
  input  wire logic [7:0]  port_b_pins_in,
  output logic      [7:0]  port_b_pins_out,
  output logic      [7:0]  port_b_pins_oe,
  input  wire logic        port_b_strobe_input,
  input  wire logic        port_b_aux_handshake_in,
  output logic             port_b_aux_handshake_out,
  output logic             port_b_aux_handshake_oe,
  output logic             port_b_service_request,
  // Transfer request
  output logic             transfer_request_pin
);

  // Pulse length in cycles, derived from the time
  localparam logic [2:0] PULSE_CYC = 3'(`PPMIH_PULSE_NS / `PPMIH_CLK_NS);

  // Address decode used only by the error answer taken at setup
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `PPMIH_OFF_STAT) && (a[1:0] == 2'b00);
  endfunction

  logic       setup;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] gen_q;
  logic [1:0] accept;
  logic [1:0] svc_en;
  logic [1:0] bitio;
  logic [1:0] xfer_q;
  logic       xfer_go;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;

  // Zero-wait answer: ready and error ride the access cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped(paddr);
    end
  end

  // Enables, sense bits and transfer request routing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gen_q <= `PPMIH_REG_RESET;
    end else if (wr_acc && paddr == `PPMIH_OFF_GEN) begin
      gen_q <= pwdata[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      localparam logic [7:0] CTRL_OFF = gi ? `PPMIH_OFF_CTRL_B : `PPMIH_OFF_CTRL_A;
      localparam logic [7:0] DIR_OFF  = gi ? `PPMIH_OFF_DIR_B : `PPMIH_OFF_DIR_A;
      localparam logic [7:0] DATA_OFF = gi ? `PPMIH_OFF_DATA_B : `PPMIH_OFF_DATA_A;

      logic        [7:0] pin_raw;
      logic              stb_raw;
      logic              aux_raw;
      logic        [9:0] sync_v;
      ppmih_byte_t       ctrl_q;
      ppmih_byte_t       dir_q;
      ppmih_byte_t       fol_q;
      ppmih_byte_t       iol_q;
      logic              fol_full_q;
      logic              iol_full_q;
      ppmih_byte_t       fil_q;
      ppmih_byte_t       fil_d;
      ppmih_byte_t       ini_q;
      ppmih_byte_t       ini_d;
      ppmih_fill_e       fill_q;
      ppmih_fill_e       fill_d;
      logic              stb_prev_q;
      logic              aux_prev_q;
      logic              stb_edge;
      logic              aux_edge;
      logic              enable;
      logic              sub00;
      logic              pop_pend_q;
      logic              pop;
      logic              strobe_flag_q;
      logic              aux_flag_q;
      logic              ready_d;
      logic              ready_q;
      logic        [2:0] pulse_q;
      logic              aux_d;
      logic              aux_out_q;
      logic              aux_oe_q;
      logic              svc_q;
      ppmih_byte_t       rd_data;

      assign pin_raw = gi ? port_b_pins_in : port_a_pins_in;
      assign stb_raw = gi ? port_b_strobe_input : port_a_strobe_input;
      assign aux_raw = gi ? port_b_aux_handshake_in : port_a_aux_handshake_in;

      // Pins settle before edges are taken, so each edge acts once
      ppmih_sync #(.W(10)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .d_in     ({aux_raw, stb_raw, pin_raw}),
        .q_out    (sync_v)
      );

      assign enable = gen_q[`PPMIH_GEN_EN_A + gi];
      assign sub00  = ctrl_q[7:6] == 2'b00;

      // Asserted edges after the sense inversion; history resets high so
      // cleared synchronisers cannot fake an edge just after reset
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          stb_prev_q <= 1'b1;
          aux_prev_q <= 1'b1;
        end else begin
          stb_prev_q <= sync_v[8] ~^ gen_q[2*gi];
          aux_prev_q <= sync_v[9] ~^ gen_q[2*gi+1];
        end
      end
      assign stb_edge = (sync_v[8] ~^ gen_q[2*gi]) && !stb_prev_q;
      assign aux_edge = (sync_v[9] ~^ gen_q[2*gi+1]) && !aux_prev_q;

      function automatic logic aux_out_q_logic();
        aux_out_q_logic = aux_out_q ~^ gen_q[2*gi+1];
      endfunction

      // Interlocked mode drops strobes that arrive while aux is negated
      assign accept[gi] = enable && sub00 && stb_edge && fill_q != fill_two &&
                          !(ctrl_q[5:3] == 3'b110 && !aux_out_q_logic());

      // Control and direction registers
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          ctrl_q <= `PPMIH_REG_RESET;
          dir_q  <= `PPMIH_REG_RESET;
        end else if (wr_acc) begin
          if (paddr == CTRL_OFF) begin
            ctrl_q <= pwdata[7:0];
          end
          if (paddr == DIR_OFF) begin
            dir_q <= pwdata[7:0];
          end
        end
      end

      // Pop is armed in setup only when data exists; fill can only grow
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          pop_pend_q <= 1'b0;
        end else begin
          pop_pend_q <= setup && !pwrite && paddr == DATA_OFF &&
                        fill_q != fill_empty && sub00;
        end
      end
      assign pop = rd_acc && pop_pend_q;

      // Two-deep input buffer: final latch first, initial behind it
      always_comb begin
        fill_d = fill_q;
        fil_d  = fil_q;
        ini_d  = ini_q;
        case (fill_q)
          fill_empty: begin
            if (accept[gi]) begin
              fill_d = fill_one;
              fil_d  = sync_v[7:0];
            end
          end
          fill_one: begin
            if (accept[gi] && pop) begin
              fil_d = sync_v[7:0];
            end else if (accept[gi]) begin
              fill_d = fill_two;
              ini_d  = sync_v[7:0];
            end else if (pop) begin
              fill_d = fill_empty;
            end
          end
          fill_two: begin
            if (pop) begin
              fill_d = fill_one;
              fil_d  = ini_q;
            end
          end
          default: fill_d = fill_empty;
        endcase
        if (!enable) begin
          fill_d = fill_empty;
        end
      end

      // Occupancy and strobe flag share one edge
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          fill_q        <= fill_empty;
          fil_q         <= `PPMIH_REG_RESET;
          ini_q         <= `PPMIH_REG_RESET;
          strobe_flag_q <= 1'b0;
        end else begin
          fill_q        <= fill_d;
          fil_q         <= fil_d;
          ini_q         <= ini_d;
          strobe_flag_q <= sub00 && fill_d != fill_empty;
        end
      end

      // Output latches; writes in 00 touch no handshake state
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          fol_q      <= `PPMIH_REG_RESET;
          iol_q      <= `PPMIH_REG_RESET;
          fol_full_q <= 1'b0;
          iol_full_q <= 1'b0;
        end else if (wr_acc && paddr == DATA_OFF) begin
          if (ctrl_q[7:6] != 2'b01) begin
            fol_q <= pwdata[7:0];
          end else if (!fol_full_q) begin
            fol_q      <= pwdata[7:0];
            fol_full_q <= 1'b1;
          end else begin
            iol_q      <= pwdata[7:0];
            iol_full_q <= 1'b1;
          end
        end else if (!enable) begin
          fol_full_q <= 1'b0;
          iol_full_q <= 1'b0;
        end else if (ctrl_q[7:6] == 2'b01 && stb_edge) begin
          // Peripheral took the final latch; advance the queue
          if (iol_full_q) begin
            fol_q      <= iol_q;
            iol_full_q <= 1'b0;
          end else begin
            fol_full_q <= 1'b0;
          end
        end
      end

      // Aux pin: space signal and four-cycle pulse timer
      assign ready_d = enable && fill_d != fill_two && !stb_edge;
      always_comb begin
        case (ctrl_q[5:3])
          3'b100:  aux_d = 1'b0;
          3'b101:  aux_d = 1'b1;
          3'b110:  aux_d = ready_d;
          3'b111:  aux_d = ready_d && (!ready_q || pulse_q != 3'h0);
          default: aux_d = 1'b0;
        endcase
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          ready_q   <= 1'b0;
          pulse_q   <= 3'h0;
          aux_out_q <= 1'b1; // Negated at low-active reset sense
          aux_oe_q  <= 1'b0;
        end else begin
          ready_q <= ready_d;
          if (!ready_d) begin
            pulse_q <= 3'h0; // Strobe edge cuts the pulse short
          end else if (!ready_q) begin
            pulse_q <= PULSE_CYC - 3'h1;
          end else if (pulse_q != 3'h0) begin
            pulse_q <= pulse_q - 3'h1;
          end
          aux_out_q <= aux_d ~^ gen_q[2*gi+1];
          aux_oe_q  <= ctrl_q[5];
        end
      end

      // Aux status flag; a set in the clear cycle wins
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          aux_flag_q <= 1'b0;
        end else if (enable && !ctrl_q[5] && aux_edge) begin
          aux_flag_q <= 1'b1;
        end else if (!enable || ctrl_q[5] ||
                     (wr_acc && paddr == `PPMIH_OFF_STAT && pwdata[2*gi+1])) begin
          aux_flag_q <= 1'b0;
        end
      end

      // Service request: strobe flag when enabled, aux flag when its irq set
      assign svc_en[gi] = ctrl_q[`PPMIH_CTRL_SVC];
      assign bitio[gi]  = ctrl_q[7];
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          svc_q <= 1'b0;
        end else begin
          svc_q <= (strobe_flag_q && svc_en[gi]) ||
                   (aux_flag_q && ctrl_q[`PPMIH_CTRL_AUXIE]);
        end
      end

      // Data read: output latch where driven, else buffer or live pin
      assign rd_data = (dir_q & fol_q) |
                       (~dir_q & (sub00 ? fil_q : sync_v[7:0]));
    end
  endgenerate

  // Read data latched at setup; alternate reads have no side effect
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      case (paddr)
        `PPMIH_OFF_GEN:    prdata <= {24'h0, gen_q};
        `PPMIH_OFF_CTRL_A: prdata <= {24'h0, g_port[0].ctrl_q};
        `PPMIH_OFF_CTRL_B: prdata <= {24'h0, g_port[1].ctrl_q};
        `PPMIH_OFF_DIR_A:  prdata <= {24'h0, g_port[0].dir_q};
        `PPMIH_OFF_DIR_B:  prdata <= {24'h0, g_port[1].dir_q};
        `PPMIH_OFF_DATA_A: prdata <= {24'h0, g_port[0].rd_data};
        `PPMIH_OFF_DATA_B: prdata <= {24'h0, g_port[1].rd_data};
        `PPMIH_OFF_ALT_A:  prdata <= {24'h0, g_port[0].sync_v[7:0]};
        `PPMIH_OFF_ALT_B:  prdata <= {24'h0, g_port[1].sync_v[7:0]};
        `PPMIH_OFF_STAT:   prdata <= {28'h0, g_port[1].aux_flag_q,
                                      g_port[1].strobe_flag_q,
                                      g_port[0].aux_flag_q,
                                      g_port[0].strobe_flag_q};
        default:           prdata <= 32'h0;
      endcase
    end
  end

  // Transfer request: one port only, silent in bit I/O submode
  assign xfer_go = gen_q[`PPMIH_GEN_XFER_EN] &&
                   (gen_q[`PPMIH_GEN_XFER_SEL] ?
                    (accept[1] && svc_en[1] && !bitio[1]) :
                    (accept[0] && svc_en[0] && !bitio[0]));
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xfer_q               <= 2'h0;
      transfer_request_pin <= 1'b0;
    end else begin
      if (xfer_go) begin
        xfer_q <= `PPMIH_XFER_CYC - 2'h1;
      end else if (xfer_q != 2'h0) begin
        xfer_q <= xfer_q - 2'h1;
      end
      transfer_request_pin <= xfer_go || xfer_q != 2'h0;
    end
  end

  // Pin drivers come straight from latches
  assign port_a_pins_out          = g_port[0].fol_q;
  assign port_a_pins_oe           = g_port[0].dir_q;
  assign port_a_aux_handshake_out = g_port[0].aux_out_q;
  assign port_a_aux_handshake_oe  = g_port[0].aux_oe_q;
  assign port_a_service_request   = g_port[0].svc_q;
  assign port_b_pins_out          = g_port[1].fol_q;
  assign port_b_pins_oe           = g_port[1].dir_q;
  assign port_b_aux_handshake_out = g_port[1].aux_out_q;
  assign port_b_aux_handshake_oe  = g_port[1].aux_oe_q;
  assign port_b_service_request   = g_port[1].svc_q;

endmodule // ppmih_top

// file: pkg/ppmih_consts.svh
// Offsets, field positions and timing counts for the mode-0 parallel ports.
// Assumes an APB slave with 8-bit byte addresses and one word per register.
`ifndef PPMIH_CONSTS_SVH
`define PPMIH_CONSTS_SVH
`define PPMIH_OFF_GEN     8'h00
`define PPMIH_OFF_CTRL_A  8'h04
`define PPMIH_OFF_CTRL_B  8'h08
`define PPMIH_OFF_DIR_A   8'h0c
`define PPMIH_OFF_DIR_B   8'h10
`define PPMIH_OFF_DATA_A  8'h14
`define PPMIH_OFF_DATA_B  8'h18
`define PPMIH_OFF_ALT_A   8'h1c
`define PPMIH_OFF_ALT_B   8'h20
`define PPMIH_OFF_STAT    8'h24
`define PPMIH_GEN_EN_A    4
`define PPMIH_GEN_XFER_SEL 6
`define PPMIH_GEN_XFER_EN 7
`define PPMIH_CTRL_SVC    1
`define PPMIH_CTRL_AUXIE  2
`define PPMIH_REG_RESET   8'h00
`define PPMIH_PULSE_NS    40
`define PPMIH_CLK_NS      10
`define PPMIH_XFER_CYC    2'h3
`endif

// file: pkg/ppmih_pkg.sv
// Types shared by the mode-0 parallel port block.
// Assumes the constants header is included by users that need numbers.
package ppmih_pkg;
  typedef enum logic [1:0] {fill_empty, fill_one, fill_two} ppmih_fill_e;
  typedef logic [7:0] ppmih_byte_t;
endpackage

// file: verification/ppmih_asserts.sv
// Checker for the APB slave and handshake pins of the port block.
// Assumes it is bound onto ppmih_top and sees only its ports.
`timescale 1ns/10ps
`include "ppmih_consts.svh"
module ppmih_asserts (
  // Clock, reset and APB
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Watched pins
  input wire logic [7:0]  port_a_pins_oe,
  input wire logic        port_a_aux_handshake_oe,
  input wire logic        port_a_service_request,
  input wire logic        port_b_aux_handshake_out,
  input wire logic        transfer_request_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic acc_w;
  // Completed good write
  assign acc_w = psel && penable && pready && pwrite && !pslverr;
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  chk_dir_write_oe: assert property (
    acc_w && paddr == `PPMIH_OFF_DIR_A |=> port_a_pins_oe == $past(pwdata[7:0]))
    else $error("driver enables differ from direction");
  chk_ctrl_aux_oe: assert property (
    acc_w && paddr == `PPMIH_OFF_CTRL_A |=> ##1 port_a_aux_handshake_oe == $past(pwdata[5], 2))
    else $error("aux enable differs from control");
  chk_xfer_three_cyc: assert property (
    $rose(transfer_request_pin) |-> transfer_request_pin[*3] ##1 !transfer_request_pin)
    else $error("transfer request not three cycles");
  chk_pulse_max_four: assert property (
    $fell(port_b_aux_handshake_out) |-> ##[1:4] port_b_aux_handshake_out)
    else $error("aux pulse too long");
  chk_alt_read_quiet: assert property (
    psel && penable && !pwrite && paddr == `PPMIH_OFF_ALT_A |=> $stable(port_a_service_request))
    else $error("alternate read disturbed service");
endmodule // ppmih_asserts

bind ppmih_top ppmih_asserts ppmih_asserts_inst (.core_clk, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .port_a_pins_oe, .port_a_aux_handshake_oe,
  .port_a_service_request, .port_b_aux_handshake_out, .transfer_request_pin);

// file: verification/ppmih_periph.sv
// Peripheral model: puts a byte on the port pins and strobes it in.
// Assumes the strobe sense bit stays at reset, so asserted is low.
`timescale 1ns/10ps
module ppmih_periph (
  // Clock and request from the bench
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] data,
  // Pin side
  output logic      [7:0] pins,
  output logic            strobe_n,
  output logic            busy
);
  logic [4:0] cnt_q = 5'h00;
  logic [7:0] pins_q = 8'h00;
  // Data leads the strobe by four cycles and outlasts it by nine
  always_ff @(posedge core_clk) begin
    if (go && cnt_q == 5'h00) begin
      pins_q <= data;
      cnt_q  <= 5'h14;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
    // Released data is inverted so a late sample cannot match by luck
    if (cnt_q == 5'h02) begin
      pins_q <= ~pins_q;
    end
  end
  assign pins     = pins_q;
  assign strobe_n = !(cnt_q >= 5'h0b && cnt_q <= 5'h10);
  assign busy     = cnt_q != 5'h00;
endmodule // ppmih_periph

// file: verification/ppmih_top_tb.sv
// Self-checking bench for the port block with a strobing peripheral.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/10ps
`include "ppmih_consts.svh"
module ppmih_top_tb;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, err, xfer_seen;
  logic [7:0]  paddr, data_a, pa_drv, pb_drv;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  port_a_pins_in, port_a_pins_out, port_a_pins_oe;
  logic [7:0]  port_b_pins_in, port_b_pins_out, port_b_pins_oe;
  logic        port_a_strobe_input, port_a_aux_handshake_in, port_a_aux_handshake_out;
  logic        port_a_aux_handshake_oe, port_a_service_request, go_a, busy_a, aux_a_drv;
  logic        port_b_strobe_input, port_b_aux_handshake_in, port_b_aux_handshake_out;
  logic        port_b_aux_handshake_oe, port_b_service_request, transfer_request_pin;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Wire levels from every driver's enable
  assign port_a_pins_in = (port_a_pins_oe & port_a_pins_out) | (~port_a_pins_oe & pa_drv);
  assign port_b_pins_in = (port_b_pins_oe & port_b_pins_out) | (~port_b_pins_oe & pb_drv);
  assign port_a_aux_handshake_in = port_a_aux_handshake_oe ? port_a_aux_handshake_out : aux_a_drv;
  assign port_b_aux_handshake_in = port_b_aux_handshake_oe ? port_b_aux_handshake_out : 1'b1;
  ppmih_top ppmih_top_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_a_pins_in, .port_a_pins_out, .port_a_pins_oe,
    .port_a_strobe_input, .port_a_aux_handshake_in, .port_a_aux_handshake_out,
    .port_a_aux_handshake_oe, .port_a_service_request, .port_b_pins_in, .port_b_pins_out,
    .port_b_pins_oe, .port_b_strobe_input, .port_b_aux_handshake_in,
    .port_b_aux_handshake_out, .port_b_aux_handshake_oe, .port_b_service_request,
    .transfer_request_pin);
  ppmih_periph periph_a (.core_clk, .go(go_a), .data(data_a), .pins(pa_drv),
    .strobe_n(port_a_strobe_input), .busy(busy_a));
  ppmih_periph periph_b (.core_clk, .go(1'b0), .data(8'h00), .pins(pb_drv),
    .strobe_n(port_b_strobe_input), .busy());
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cut a hang short; ceiling far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (transfer_request_pin === 1'b1) xfer_seen <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; holds everything until ready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge core_clk);
    go_a <= 1'b1;
    data_a <= d;
    @(posedge core_clk);
    go_a <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (busy_a);
  endtask
  task automatic t_reset();
    check(port_a_aux_handshake_out, 1'b1);
    check(port_a_pins_oe, 8'h00);
    apb(0, `PPMIH_OFF_CTRL_A, 0);
    check(rd, 32'h0);
    apb(0, `PPMIH_OFF_CTRL_B, 0);
    check(rd, 32'h0);
    // Submode moves on any control write, whatever the enables
    apb(1, `PPMIH_OFF_CTRL_A, 32'hc7);
    apb(0, `PPMIH_OFF_CTRL_A, 0);
    check(rd, 32'hc7);
    apb(1, `PPMIH_OFF_CTRL_B, 32'h5b);
    apb(0, `PPMIH_OFF_CTRL_B, 0);
    check(rd, 32'h5b);
    apb(1, `PPMIH_OFF_CTRL_B, 0);
    apb(0, 8'h28, 0);
    check(err, 1'b1);
  endtask
  task automatic t_capture();
    apb(1, `PPMIH_OFF_DIR_A, 0);
    apb(1, `PPMIH_OFF_CTRL_A, 32'h32);
    apb(1, `PPMIH_OFF_GEN, 32'h90);
    repeat (4) @(posedge core_clk);
    check(port_a_aux_handshake_out, 1'b0);
    send(8'h3c);
    send(8'hc3);
    check(port_a_aux_handshake_out, 1'b1);
    check(port_a_service_request, 1'b1);
    check(xfer_seen, 1'b1);
    send(8'h77);
    repeat (4) @(posedge core_clk);
    apb(0, `PPMIH_OFF_STAT, 0);
    check(rd[0], 1'b1);
    apb(0, `PPMIH_OFF_ALT_A, 0);
    check(rd, 32'h88);
    apb(0, `PPMIH_OFF_DATA_A, 0);
    check(rd, 32'h3c);
    apb(0, `PPMIH_OFF_DATA_A, 0);
    check(rd, 32'hc3);
    apb(0, `PPMIH_OFF_STAT, 0);
    check(rd[0], 1'b0);
    check(port_a_service_request, 1'b0);
    check(port_a_aux_handshake_out, 1'b0);
  endtask
  task automatic t_output();
    apb(1, `PPMIH_OFF_DIR_A, 32'hf0);
    apb(1, `PPMIH_OFF_DATA_A, 32'h5a);
    @(posedge core_clk);
    check(port_a_pins_out, 8'h5a);
    check(port_a_pins_oe, 8'hf0);
    check(port_a_aux_handshake_out, 1'b0);
    apb(0, `PPMIH_OFF_DATA_A, 0);
    check(rd & 32'hf0, 32'h50);
    apb(1, `PPMIH_OFF_DIR_A, 0);
  endtask
  task automatic t_aux();
    send(8'h11);
    apb(1, `PPMIH_OFF_GEN, 0);
    repeat (2) @(posedge core_clk);
    check(port_a_aux_handshake_out, 1'b1);
    apb(1, `PPMIH_OFF_GEN, 32'h90);
    apb(0, `PPMIH_OFF_STAT, 0);
    check(rd[0], 1'b0);
    apb(1, `PPMIH_OFF_CTRL_A, 32'h20);
    repeat (2) @(posedge core_clk);
    check(port_a_aux_handshake_out, 1'b1);
    check(port_a_aux_handshake_oe, 1'b1);
    apb(1, `PPMIH_OFF_CTRL_A, 32'h28);
    repeat (2) @(posedge core_clk);
    check(port_a_aux_handshake_out, 1'b0);
    apb(1, `PPMIH_OFF_CTRL_A, 32'h00);
    // Let the released aux pin settle negated so the fall is a real edge
    repeat (6) @(posedge core_clk);
    aux_a_drv <= 1'b0;
    repeat (8) @(posedge core_clk);
    apb(0, `PPMIH_OFF_STAT, 0);
    check(rd[1], 1'b1);
    apb(1, `PPMIH_OFF_STAT, 32'h2);
    apb(0, `PPMIH_OFF_STAT, 0);
    check(rd[1], 1'b0);
    aux_a_drv <= 1'b1;
  endtask
  task automatic t_pulsed();
    int lo;
    lo = 0;
    apb(1, `PPMIH_OFF_CTRL_B, 32'h38);
    apb(1, `PPMIH_OFF_GEN, 32'h20);
    repeat (20) begin
      @(posedge core_clk);
      if (port_b_aux_handshake_out === 1'b0) lo++;
    end
    check(lo, 32'd4);
  endtask
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go_a = 1'b0;
    data_a = 8'h00;
    aux_a_drv = 1'b1;
    xfer_seen = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_capture();
    t_output();
    t_aux();
    t_pulsed();
    summarize();
  end
endmodule // ppmih_top_tb
